/* File: rtl/fpecr_pkg.sv */
// package: constants and types for the polarity, revision and endpoint configuration register bank
package fpecr_pkg;

  // ----------------------------------------------------------------
  // command protocol register addresses
  // ----------------------------------------------------------------
  localparam logic [5:0]  ADDR_POLARITY   = 6'h04;
  localparam logic [5:0]  ADDR_REVISION   = 6'h05;
  localparam logic [5:0]  ADDR_EPCFG_BASE = 6'h06;   // endpoints 2,4,6,8 at 0x06..0x09
  localparam logic [5:0]  ADDR_IND_LO     = 6'h3a;
  localparam logic [5:0]  ADDR_IND_HI     = 6'h3b;
  localparam logic [5:0]  ADDR_IND_DATA   = 6'h3c;
  localparam logic [15:0] IND_POLARITY_FULL = 16'he609;

  // ----------------------------------------------------------------
  // polarity register fields
  // ----------------------------------------------------------------
  localparam int POL_WAKE   = 7;
  localparam int POL_PACKET_COMMIT_STROBE = 5;
  localparam int POL_OE     = 4;
  localparam int POL_RD     = 3;
  localparam int POL_WR     = 2;
  localparam int POL_EMPTY  = 1;
  localparam int POL_FULL   = 0;
  localparam logic [7:0] POL_RESET     = 8'h00;
  localparam logic [7:0] POL_DIRECT_WR = 8'ha3;  // bits writable through the ordinary register
  localparam logic [7:0] POL_FULL_WR   = 8'hbf;  // bits writable through the indirect twin

  // ----------------------------------------------------------------
  // endpoint configuration
  // ----------------------------------------------------------------
  localparam int          EP_COUNT     = 4;
  localparam logic [7:0]  EPCFG_RESET_OUT = 8'ha2;
  localparam logic [7:0]  EPCFG_RESET_IN  = 8'he2;
  localparam logic [7:0]  EPCFG_FIXED_MASK = 8'h0b; // size and depth bits on endpoints 4 and 8
  localparam int          EP_ENABLE    = 7;
  localparam int          EP_DIR       = 6;
  localparam int          EP_TYPE_LO   = 4;
  localparam int          EP_STALL     = 2;
  localparam logic [1:0]  TYPE_INVALID = 2'b00;
  localparam logic [1:0]  TYPE_ISO     = 2'b01;
  localparam logic [1:0]  TYPE_BULK    = 2'b10;
  localparam logic [1:0]  TYPE_INTR    = 2'b11;
  localparam logic [1:0]  DEPTH_QUAD   = 2'b00;
  localparam logic [1:0]  DEPTH_BAD    = 2'b01;
  localparam logic [1:0]  DEPTH_DOUBLE = 2'b10;
  localparam logic [1:0]  DEPTH_TRIPLE = 2'b11;
  localparam logic [3:0]  STATUS_EP_MASK = 4'hf;

  typedef struct packed {
    logic       enable;
    logic       dir_in;
    logic       transfer_kind_hi;
    logic       transfer_kind_lo;
    logic       size_1k;
    logic       stall;
    logic       ring_depth_hi;
    logic       ring_depth_lo;
  } fpecr_epcfg_t;

  // command port from the external master, same clock domain
  typedef struct packed {
    logic       wr;       // one-cycle write strobe
    logic       is_addr;  // 1: command address write, 0: nibble data write
    logic       rd;       // one-cycle read of the current address
    logic [7:0] data;
  } fpecr_cmd_t;

  typedef enum logic [0:0] {
    NIB_UPPER = 1'b0,
    NIB_LOWER = 1'b1
  } fpecr_nib_t;

endpackage : fpecr_pkg

/* File: rtl/fpecr_regs.sv */
// module: pin polarity, silicon revision and endpoint configuration registers behind the command protocol
`timescale 1ns/1ps
module fpecr_regs #(
  parameter logic [7:0] REVISION = 8'h2a   // arbitrary value
) (
  input  wire logic                                 clk_i,
  input  wire logic                                 resetn_i,
  input  wire fpecr_pkg::fpecr_cmd_t                cmd_i,
  output logic [7:0]                                rd_data_o,
  output logic                                      rd_valid_o,
  input  wire logic                                 wake_pin_i,
  input  wire logic                                 packet_commit_strobe_i,
  input  wire logic                                 fifo_write_strobe_i,
  input  wire logic                                 fifo_read_strobe_i,
  input  wire logic                                 fifo_output_enable_pin_i,
  input  wire logic                                 fifo_empty_i,
  input  wire logic                                 fifo_full_i,
  output logic                                      wake_o,
  output logic                                      packet_commit_o,
  output logic                                      fifo_write_o,
  output logic                                      fifo_read_o,
  output logic                                      fifo_output_enable_o,
  output logic                                      empty_flag_o,
  output logic                                      full_flag_o,
  input  wire logic [7:0]                           status_ep_i,
  output logic                                      status_stall_o,
  output fpecr_pkg::fpecr_epcfg_t [fpecr_pkg::EP_COUNT-1:0] ep_cfg_o,
  output logic [fpecr_pkg::EP_COUNT-1:0]            ep_stall_handshake_o
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // five pins come from outside the clock domain; only sync2 is read
  // the first stage may settle late, so it feeds nothing but the second
  logic [4:0] pin_raw;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;

  assign pin_raw = {wake_pin_i, packet_commit_strobe_i, fifo_write_strobe_i,
                    fifo_read_strobe_i, fifo_output_enable_pin_i};

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sync1_r <= 5'h00;
      sync2_r <= 5'h00;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  // ----------------------------------------------------------------
  // command decode state
  // ----------------------------------------------------------------
  logic [5:0]             cur_addr_r,  cur_addr_nxt;
  fpecr_pkg::fpecr_nib_t  nib_r,       nib_nxt;
  logic [3:0]             upper_r,     upper_nxt;
  logic [7:0]             ind_lo_r,    ind_lo_nxt;
  logic [7:0]             ind_hi_r,    ind_hi_nxt;
  logic [7:0]             pol_r,       pol_nxt;
  logic                   byte_done;
  logic [7:0]             wr_byte;

  // a byte lands on the second nibble; an address write restarts the pair
  // so a lone upper nibble before an address write is simply dropped
  assign byte_done = cmd_i.wr && !cmd_i.is_addr && (nib_r == fpecr_pkg::NIB_LOWER);
  assign wr_byte   = {upper_r, cmd_i.data[3:0]};

  always_comb begin
    cur_addr_nxt = cur_addr_r;
    nib_nxt      = nib_r;
    upper_nxt    = upper_r;
    ind_lo_nxt   = ind_lo_r;
    ind_hi_nxt   = ind_hi_r;
    pol_nxt      = pol_r;
    if (cmd_i.wr && cmd_i.is_addr) begin
      cur_addr_nxt = cmd_i.data[5:0];
      nib_nxt      = fpecr_pkg::NIB_UPPER;
    end else if (cmd_i.wr) begin
      case (nib_r)
        fpecr_pkg::NIB_UPPER: begin
          upper_nxt = cmd_i.data[3:0];
          nib_nxt   = fpecr_pkg::NIB_LOWER;
        end
        fpecr_pkg::NIB_LOWER: begin
          nib_nxt = fpecr_pkg::NIB_UPPER;
        end
        default: begin
          nib_nxt = fpecr_pkg::NIB_UPPER;
        end
      endcase
    end
    if (byte_done) begin
      case (cur_addr_r)
        fpecr_pkg::ADDR_IND_LO: begin
          ind_lo_nxt = wr_byte;
        end
        fpecr_pkg::ADDR_IND_HI: begin
          ind_hi_nxt = wr_byte;
        end
        fpecr_pkg::ADDR_IND_DATA: begin
          if ({ind_hi_r, ind_lo_r} == fpecr_pkg::IND_POLARITY_FULL) begin
            pol_nxt = wr_byte & fpecr_pkg::POL_FULL_WR;
          end
        end
        fpecr_pkg::ADDR_POLARITY: begin
          // write, read and output enable polarity bits (and bit 6) keep their value here
          pol_nxt = (pol_r & ~fpecr_pkg::POL_DIRECT_WR) | (wr_byte & fpecr_pkg::POL_DIRECT_WR);
        end
        default: begin
          pol_nxt = pol_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cur_addr_r <= 6'h00;
      nib_r      <= fpecr_pkg::NIB_UPPER;
      upper_r    <= 4'h0;
      ind_lo_r   <= 8'h00;
      ind_hi_r   <= 8'h00;
      // strobe, read and enable polarity come up active low
      pol_r      <= fpecr_pkg::POL_RESET;
    end else begin
      cur_addr_r <= cur_addr_nxt;
      nib_r      <= nib_nxt;
      upper_r    <= upper_nxt;
      ind_lo_r   <= ind_lo_nxt;
      ind_hi_r   <= ind_hi_nxt;
      pol_r      <= pol_nxt;
    end
  end

  // ----------------------------------------------------------------
  // endpoint configuration registers
  // ----------------------------------------------------------------
  logic [fpecr_pkg::EP_COUNT-1:0][7:0] ep_r;
  logic [fpecr_pkg::EP_COUNT-1:0][7:0] ep_nxt;

  genvar g;
  generate
    for (g = 0; g < fpecr_pkg::EP_COUNT; g++) begin : g_ep
      // endpoints 2,4 (index 0,1) come up out, 6,8 (index 2,3) come up in
      localparam logic [7:0] RST   = (g < 2) ? fpecr_pkg::EPCFG_RESET_OUT
                                             : fpecr_pkg::EPCFG_RESET_IN;
      // odd index is endpoint 4 or 8: size and depth are fixed
      localparam logic [7:0] FIXED = (g % 2 == 1) ? fpecr_pkg::EPCFG_FIXED_MASK : 8'h00;

      always_comb begin
        ep_nxt[g] = ep_r[g];
        if (byte_done && (cur_addr_r == fpecr_pkg::ADDR_EPCFG_BASE + 6'(g))) begin
          // each register is written alone, so directions stay independent
          // fixed bits are forced back on every write, so no write can move them
          ep_nxt[g] = (wr_byte & ~FIXED) | (RST & FIXED);
        end
      end

      // reset loads the per-endpoint direction default
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ep_r[g] <= RST;
        end else begin
          ep_r[g] <= ep_nxt[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------
  logic [7:0] rd_data_nxt;
  logic [7:0] rd_data_r;
  logic       rd_valid_r;
  logic       rd_valid_nxt;

  // unmapped addresses read as zero; read is of the last address written
  // 0x3a..0x3c are staging registers and read back as zero
  always_comb begin
    rd_data_nxt  = rd_data_r;
    rd_valid_nxt = cmd_i.rd;
    if (cmd_i.rd) begin
      case (cur_addr_r)
        fpecr_pkg::ADDR_POLARITY:         rd_data_nxt = pol_r;
        fpecr_pkg::ADDR_REVISION:         rd_data_nxt = REVISION;
        fpecr_pkg::ADDR_EPCFG_BASE:       rd_data_nxt = ep_r[0];
        fpecr_pkg::ADDR_EPCFG_BASE + 6'h1: rd_data_nxt = ep_r[1];
        fpecr_pkg::ADDR_EPCFG_BASE + 6'h2: rd_data_nxt = ep_r[2];
        fpecr_pkg::ADDR_EPCFG_BASE + 6'h3: rd_data_nxt = ep_r[3];
        default:                          rd_data_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_data_r  <= 8'h00;
      rd_valid_r <= 1'b0;
    end else begin
      rd_data_r  <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  assign rd_data_o  = rd_data_r;
  assign rd_valid_o = rd_valid_r;

  // ----------------------------------------------------------------
  // pin polarity and endpoint outputs
  // ----------------------------------------------------------------
  logic [6:0] pin_nxt;
  logic [6:0] pin_r;
  logic [fpecr_pkg::EP_COUNT-1:0] stall_nxt;
  logic [fpecr_pkg::EP_COUNT-1:0] stall_r;
  logic       gs_nxt;
  logic       gs_r;
  logic [1:0] gs_idx;
  logic       gs_hit;

  // flag inputs are same-clock status, so they skip the synchroniser
  // inputs become active-high internally: xor with inverted polarity bit
  always_comb begin
    pin_nxt[6] = sync2_r[4] ^ ~pol_r[fpecr_pkg::POL_WAKE];
    pin_nxt[5] = sync2_r[3] ^ ~pol_r[fpecr_pkg::POL_PACKET_COMMIT_STROBE];
    pin_nxt[4] = sync2_r[2] ^ ~pol_r[fpecr_pkg::POL_WR];
    pin_nxt[3] = sync2_r[1] ^ ~pol_r[fpecr_pkg::POL_RD];
    pin_nxt[2] = sync2_r[0] ^ ~pol_r[fpecr_pkg::POL_OE];
    pin_nxt[1] = fifo_empty_i ~^ pol_r[fpecr_pkg::POL_EMPTY];
    pin_nxt[0] = fifo_full_i ~^ pol_r[fpecr_pkg::POL_FULL];
  end

  // stall answer only for a valid bulk endpoint; disabled ones answer nothing
  always_comb begin
    for (int i = 0; i < fpecr_pkg::EP_COUNT; i++) begin
      // type is checked too, so a stall bit left on an iso endpoint stays silent
      stall_nxt[i] = ep_r[i][fpecr_pkg::EP_ENABLE] && ep_r[i][fpecr_pkg::EP_STALL] &&
                     (ep_r[i][fpecr_pkg::EP_TYPE_LO +: 2] == fpecr_pkg::TYPE_BULK);
    end
  end

  // endpoint number 2,4,6,8 maps to index 0..3; bit 7 must match direction
  always_comb begin
    gs_idx = 2'(((status_ep_i[3:0] & fpecr_pkg::STATUS_EP_MASK) >> 1) - 4'h1);
    gs_hit = (status_ep_i[3:0] == 4'h2) || (status_ep_i[3:0] == 4'h4) ||
             (status_ep_i[3:0] == 4'h6) || (status_ep_i[3:0] == 4'h8);
    // a request naming the wrong direction reads as not stalled
    gs_nxt = gs_hit && (status_ep_i[7] == ep_r[gs_idx][fpecr_pkg::EP_DIR]) &&
             ep_r[gs_idx][fpecr_pkg::EP_STALL];
  end

  // one register stage for pins, flags and handshakes keeps every output a flop
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pin_r   <= 7'h00;
      stall_r <= '0;
      gs_r    <= 1'b0;
    end else begin
      pin_r   <= pin_nxt;
      stall_r <= stall_nxt;
      gs_r    <= gs_nxt;
    end
  end

  // outputs come straight from the registers above
  assign wake_o               = pin_r[6];
  assign packet_commit_o      = pin_r[5];
  assign fifo_write_o         = pin_r[4];
  assign fifo_read_o          = pin_r[3];
  assign fifo_output_enable_o = pin_r[2];
  assign empty_flag_o         = pin_r[1];
  assign full_flag_o          = pin_r[0];
  assign status_stall_o       = gs_r;
  assign ep_stall_handshake_o = stall_r;
  assign ep_cfg_o             = ep_r;

endmodule : fpecr_regs

/* File: verif/fifo_polarity_endpoint_config_regs_tb.sv */
// testbench: register bank scenarios driven through the master model
`timescale 1ns/1ps
module fifo_polarity_endpoint_config_regs_tb;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic                  clk_i = 1'b0;
  logic                  resetn_i = 1'b0;
  fpecr_pkg::fpecr_cmd_t cmd;
  logic [7:0]            rd_data;
  logic [7:0]            status_ep = 8'h00;
  logic                  rd_valid, stall, ef_o, ff_o, ok;
  logic                  fe = 1'b0, ff = 1'b0;
  logic [4:0]            pin = 5'h00; // wake, commit, write, read, output enable
  logic [4:0]            pout;
  logic [3:0]            hs;
  fpecr_pkg::fpecr_epcfg_t [3:0] cfg;
  int                    error_cnt = 0, n_tests = 0;

  initial forever #2 clk_i = ~clk_i;
  fpecr_master u_fpecr_master (.clk_i(clk_i), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .cmd_o(cmd));
  fpecr_regs #(.REVISION(REV)) u_fpecr_regs (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_i(cmd),
    .rd_data_o(rd_data), .rd_valid_o(rd_valid), .wake_pin_i(pin[4]), .packet_commit_strobe_i(pin[3]),
    .fifo_write_strobe_i(pin[2]), .fifo_read_strobe_i(pin[1]), .fifo_output_enable_pin_i(pin[0]),
    .fifo_empty_i(fe), .fifo_full_i(ff), .wake_o(pout[4]), .packet_commit_o(pout[3]),
    .fifo_write_o(pout[2]), .fifo_read_o(pout[1]), .fifo_output_enable_o(pout[0]),
    .empty_flag_o(ef_o), .full_flag_o(ff_o), .status_ep_i(status_ep), .status_stall_o(stall),
    .ep_cfg_o(cfg), .ep_stall_handshake_o(hs));

  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task automatic cmp8(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : cmp8
  task automatic rd_chk(input logic [5:0] adr, input logic [7:0] e);
    logic [7:0] v;
    u_fpecr_master.rd_reg(adr, v, ok);
    cmp8({7'h0, ok}, 8'h01);
    cmp8(v, e);
  endtask : rd_chk
  // every pin level against the polarity bits, then both flag senses
  task automatic pins_chk(input logic [7:0] pol);
    for (int p = 0; p < 2; p++) begin
      pin = {5{p[0]}};
      repeat (4) @(posedge clk_i);
      #1;
      cmp8({3'h0, pout}, {3'h0, ~(pin ^ {pol[7], pol[5], pol[2], pol[3], pol[4]})});
      fe = p[0];
      ff = ~p[0];
      @(posedge clk_i);
      #1;
      cmp8({6'h0, ef_o, ff_o}, {6'h0, ~(fe ^ pol[1]), ~(ff ^ pol[0])});
    end
  endtask : pins_chk

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd_chk(fpecr_pkg::ADDR_POLARITY, 8'h00);
    rd_chk(fpecr_pkg::ADDR_REVISION, REV);
    for (int i = 0; i < 4; i++) begin
      rd_chk(fpecr_pkg::ADDR_EPCFG_BASE + 6'(i), i < 2 ? 8'ha2 : 8'he2);
    end
    pins_chk(8'h00);
  endtask : t_reset
  // write, read and output enable bits and bit six refuse the ordinary path; revision is fixed
  task automatic t_direct();
    u_fpecr_master.wr_reg(fpecr_pkg::ADDR_POLARITY, 8'hff);
    rd_chk(fpecr_pkg::ADDR_POLARITY, 8'ha3);
    u_fpecr_master.wr_reg(fpecr_pkg::ADDR_REVISION, 8'h00);
    rd_chk(fpecr_pkg::ADDR_REVISION, REV);
    rd_chk(6'h20, 8'h00);
    pins_chk(8'ha3);
  endtask : t_direct
  task automatic t_indirect();
    u_fpecr_master.pol_rmw(8'h1c, ok);
    cmp8({7'h0, ok}, 8'h01);
    rd_chk(fpecr_pkg::ADDR_POLARITY, 8'hbf);
    pins_chk(8'hbf);
    u_fpecr_master.ind_wr(16'he608, 8'h00);
    rd_chk(fpecr_pkg::ADDR_POLARITY, 8'hbf);
    u_fpecr_master.ind_wr(fpecr_pkg::IND_POLARITY_FULL, 8'h00);
    rd_chk(fpecr_pkg::ADDR_POLARITY, 8'h00);
  endtask : t_indirect
  task automatic t_epcfg();
    u_fpecr_master.wr_reg(6'h06, 8'hfb);
    u_fpecr_master.wr_reg(6'h07, 8'hff);
    u_fpecr_master.wr_reg(6'h08, 8'ha2);
    rd_chk(6'h06, 8'hfb);
    rd_chk(6'h07, 8'hf6);
    rd_chk(6'h08, 8'ha2);
    u_fpecr_master.wr_reg(6'h09, 8'he6);
    status_ep = 8'h88;
    repeat (2) @(posedge clk_i);
    #1;
    cmp8({3'h0, stall, hs}, 8'h18);
    status_ep = 8'h08;
    u_fpecr_master.wr_reg(6'h06, 8'h96);
    cmp8({3'h0, stall, hs}, 8'h08);
    status_ep = 8'h02;
    repeat (2) @(posedge clk_i);
    #1;
    cmp8({7'h0, stall}, 8'h01);
    u_fpecr_master.wr_reg(6'h08, 8'h62);
    cmp8(cfg[2], 8'h62);
  endtask : t_epcfg

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  initial begin
    repeat (10) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    t_reset();
    t_direct();
    t_indirect();
    t_epcfg();
    summarize();
  end
  // watchdog: running out counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end
endmodule : fifo_polarity_endpoint_config_regs_tb

/* File: verif/fpecr_master.sv */
// partner: external master issuing command address, nibble and read cycles
`timescale 1ns/1ps
module fpecr_master (
  input  wire logic             clk_i,
  input  wire logic [7:0]       rd_data_i,
  input  wire logic             rd_valid_i,
  output fpecr_pkg::fpecr_cmd_t cmd_o
);
  initial cmd_o = '0;
  // one command cycle: launched after an edge, held to the next edge
  task automatic cyc(input logic wr, a, rd, input logic [7:0] d);
    cmd_o = {wr, a, rd, d}; // packed order: wr, is_addr, rd, data
    @(posedge clk_i);
    #1;
  endtask : cyc
  // address, upper nibble, lower nibble, then idle so nothing repeats
  task automatic wr_reg(input logic [5:0] adr, input logic [7:0] v);
    cyc(1'b1, 1'b1, 1'b0, {2'h0, adr});
    cyc(1'b1, 1'b0, 1'b0, {4'h0, v[7:4]});
    cyc(1'b1, 1'b0, 1'b0, {4'h0, v[3:0]});
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
  endtask : wr_reg
  // answer is taken one edge after the read strobe
  task automatic rd_reg(input logic [5:0] adr, output logic [7:0] v, output logic ok);
    cyc(1'b1, 1'b1, 1'b0, {2'h0, adr});
    cyc(1'b0, 1'b0, 1'b1, 8'h00);
    ok = rd_valid_i;
    v = rd_data_i;
    cyc(1'b0, 1'b0, 1'b0, 8'h00);
  endtask : rd_reg
  task automatic ind_wr(input logic [15:0] adr, input logic [7:0] v);
    wr_reg(fpecr_pkg::ADDR_IND_LO, adr[7:0]);
    wr_reg(fpecr_pkg::ADDR_IND_HI, adr[15:8]);
    wr_reg(fpecr_pkg::ADDR_IND_DATA, v);
  endtask : ind_wr
  // read-modify-write keeps the other polarity settings intact
  task automatic pol_rmw(input logic [7:0] set, output logic ok);
    logic [7:0] v;
    rd_reg(fpecr_pkg::ADDR_POLARITY, v, ok);
    ind_wr(fpecr_pkg::IND_POLARITY_FULL, v | set);
  endtask : pol_rmw
endmodule : fpecr_master

/* File: verif/fpecr_regs_sva.sv */
// checker: port-level properties of the polarity and endpoint register bank
`timescale 1ns/1ps
module fpecr_regs_sva (
  input wire logic                                          clk_i,
  input wire logic                                          resetn_i,
  input wire fpecr_pkg::fpecr_cmd_t                         cmd_i,
  input wire logic [7:0]                                    rd_data_o,
  input wire logic                                          rd_valid_o,
  input wire logic                                          fifo_empty_i,
  input wire logic                                          fifo_full_i,
  input wire logic                                          empty_flag_o,
  input wire logic                                          full_flag_o,
  input wire logic [7:0]                                    status_ep_i,
  input wire logic                                          status_stall_o,
  input wire fpecr_pkg::fpecr_epcfg_t [fpecr_pkg::EP_COUNT-1:0] ep_cfg_o,
  input wire logic [fpecr_pkg::EP_COUNT-1:0]                ep_stall_handshake_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // ----------------------------------------------------------------
  // read path and flag sense
  // ----------------------------------------------------------------
  // a status edge with no polarity write near it must flip the flag
  sequence emp_step_s;
    $changed(fifo_empty_i) && !cmd_i.wr && !$past(cmd_i.wr) && $past(resetn_i);
  endsequence
  sequence full_step_s;
    $changed(fifo_full_i) && !cmd_i.wr && !$past(cmd_i.wr) && $past(resetn_i);
  endsequence
  rd_valid_a: assert property (cmd_i.rd |=> rd_valid_o) else $error("read gave no valid");
  rd_hold_a: assert property (!rd_valid_o |-> $stable(rd_data_o)) else $error("read data moved");
  empty_sense_a: assert property (emp_step_s |=> $changed(empty_flag_o)) else $error("empty flag stuck");
  full_sense_a: assert property (full_step_s |=> $changed(full_flag_o)) else $error("full flag stuck");

  // ----------------------------------------------------------------
  // endpoint configuration
  // ----------------------------------------------------------------
  ep4_fixed_a: assert property ((ep_cfg_o[1] & fpecr_pkg::EPCFG_FIXED_MASK) == 8'h02)
    else $error("ep4 fixed bits moved");
  ep8_fixed_a: assert property ((ep_cfg_o[3] & fpecr_pkg::EPCFG_FIXED_MASK) == 8'h02)
    else $error("ep8 fixed bits moved");
  // handshake is judged only once the config has settled for a cycle
  for (genvar i = 0; i < fpecr_pkg::EP_COUNT; i++) begin : g_hs
    stall_hs_a: assert property ($stable(ep_cfg_o[i]) |->
      ep_stall_handshake_o[i] == (ep_cfg_o[i].enable && ep_cfg_o[i].stall
      && {ep_cfg_o[i].transfer_kind_hi, ep_cfg_o[i].transfer_kind_lo} == 2'b10))
      else $error("stall handshake wrong");
  end
  status_match_a: assert property (status_ep_i == 8'h02 && !ep_cfg_o[0].dir_in |=>
    status_stall_o == $past(ep_cfg_o[0].stall)) else $error("status stall wrong");
  status_dir_a: assert property (status_ep_i == 8'h08 && ep_cfg_o[3].dir_in |=> !status_stall_o)
    else $error("status ignored direction");
endmodule : fpecr_regs_sva

bind fpecr_regs fpecr_regs_sva u_fpecr_regs_sva (.clk_i, .resetn_i, .cmd_i, .rd_data_o, .rd_valid_o,
  .fifo_empty_i, .fifo_full_i, .empty_flag_o, .full_flag_o, .status_ep_i, .status_stall_o, .ep_cfg_o,
  .ep_stall_handshake_o);
